// file: hw/octal_dac_command_decoder.sv
// Command decoder for an octal voltage-output converter behind a serial link.
// Assumes the link master frames each write and that pins are asynchronous to i_mclk.
// Contract
// - Assemble 24 serial bits into one word, decode only when complete.
// - Bits 23 to 20 hold the command code.
// - Bits 19 to 16 hold the channel address.
// - Full variant uses bits 15..0; narrow variant ignores the four lowest bits.
// - Command 1001 bit 22 selects two-byte transfers reusing the command byte.
// - Command 1000 bit 0 turns the internal reference on or off.
// - Reference set-up bit 1 selects the reference value.
// - Internal reference is off after power-up.
// - Converter registers start at zero or midscale power-on code.
// - Command 0111 returns registers and outputs to power-on state.
// - Load and clear pins are ignored during power-on reset.
// - Command 0100 bits 9:8 select normal or one of three power-down modes.
// - Power command bits 7..0 pick which channels take the mode.
// - Reference powers down only when all eight channels are powered down.
// - Power-down leaves converter register contents unchanged.
// - On power-up, output takes input register if load low, else old value.
// - Falling edge of the clear pin triggers a clear without the serial clock.
// - Clear loads every input and converter register with the clear code.
// - Command 0101 bits 1:0 pick zero, midscale, full-scale or no clear.
// - Clear code selection resets to zero volts.
// - Cleared state ends when the next valid write completes.
// - Clear during a write aborts it and discards the partial word.
// - Commands 0000 to 0011 write, update, write-update-all, write-and-update.
// - Command 0110 loads per-channel override making each write update outputs.
`timescale 1ns/100ps
module octal_dac_command_decoder
    import dac_cmd_pkg::*;
#(
    parameter bit TWELVE_BIT = 1'b0,
    parameter bit MIDSCALE_POR = 1'b0
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_link_clk,
    input wire logic i_link_frame,
    input wire logic i_link_bit,
    input wire logic i_load_outputs_n,
    input wire logic i_clear_n,
    output logic [7:0][15:0] o_dac_code,
    output logic [7:0][1:0] o_power_mode,
    output logic o_ref_enable,
    output logic o_ref_select,
    output logic o_ref_powered,
    output logic o_clear_active,
    output logic o_multi_byte
);
    typedef struct packed {
        logic [7:0][15:0] inp;
        logic [7:0][15:0] dac;
        logic [7:0][1:0] pd;
        logic [7:0] ovr;
        logic [1:0] clr_sel;
        logic ref_en;
        logic ref_sel;
        logic ref_pwr;
        logic mb;
        logic clr_act;
        logic discard;
        logic tog_seen;
        logic clr_prev;
        logic load_outputs_n_prev;
    } dec_state_t;

    localparam logic [15:0] POR_CODE = MIDSCALE_POR ? CODE_MID : CODE_ZERO;

    function automatic dec_state_t por_state();
        dec_state_t s;
        s = '0;
        s.inp = {NUM_CH{POR_CODE}};
        s.dac = {NUM_CH{POR_CODE}};
        s.clr_sel = CLR_ZERO;
        s.ref_en = 1'b0;
        s.clr_prev = 1'b1;
        s.load_outputs_n_prev = 1'b1;
        return s;
    endfunction : por_state

    localparam dec_state_t POR_STATE = por_state();

    dec_state_t st;
    dec_state_t next_st;

    logic [23:0] link_word;
    logic link_toggle;
    logic [3:0] synced;
    logic tog_s;
    logic frame_s;
    logic clr_s;
    logic load_outputs_n_s;
    logic tog_ev;
    logic clr_fall;
    logic load_outputs_n_fall;
    logic [3:0] cmd;
    logic [7:0] mask;
    logic [15:0] code;

    link_shifter u_shifter (
        .i_link_clk(i_link_clk),
        .i_sys_rst(i_sys_rst),
        .i_frame(i_link_frame),
        .i_bit(i_link_bit),
        .i_two_byte(st.mb),
        .o_word(link_word),
        .o_word_toggle(link_toggle)
    );

    // Clear and load pins idle high in reset, so no edge can be seen until they settle after release.
    level_sync #(.W(4), .RST_VAL(SYNC_RST)) u_sync (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_async({link_toggle, i_link_frame, i_clear_n, i_load_outputs_n}),
        .o_sync(synced)
    );

    assign {tog_s, frame_s, clr_s, load_outputs_n_s} = synced;
    assign tog_ev = tog_s != st.tog_seen;
    assign clr_fall = st.clr_prev & ~clr_s;
    assign load_outputs_n_fall = st.load_outputs_n_prev & ~load_outputs_n_s;
    assign cmd = link_word[CMD_HI:CMD_LO];
    assign mask = chan_mask(link_word[ADDR_HI:ADDR_LO]);
    assign code = data_code(link_word, TWELVE_BIT);

    always_comb begin
        logic [7:0] down;
        down = '0;
        next_st = st;
        next_st.tog_seen = tog_s;
        next_st.clr_prev = clr_s;
        next_st.load_outputs_n_prev = load_outputs_n_s;
        if (clr_fall) begin
            // A word landing in the same cycle as a clear is dropped with the frame.
            next_st.discard = frame_s | tog_ev;
            if (st.clr_sel != CLR_NOOP) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    next_st.inp[i] = clear_value(st.clr_sel);
                    next_st.dac[i] = clear_value(st.clr_sel);
                end
                next_st.clr_act = 1'b1;
            end
        end else begin
            if (load_outputs_n_fall) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (!st.ovr[i]) begin
                        next_st.dac[i] = st.inp[i];
                    end
                end
            end
            if (st.discard && tog_ev) begin
                next_st.discard = 1'b0;
            end else if (st.discard && !frame_s) begin
                next_st.discard = 1'b0;
            end else if (tog_ev) begin
                next_st.clr_act = 1'b0;
                unique case (cmd)
                    CMD_WR_INPUT: begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (mask[i]) begin
                                next_st.inp[i] = code;
                                if (!load_outputs_n_s || st.ovr[i]) begin
                                    next_st.dac[i] = code;
                                end
                            end
                        end
                    end
                    CMD_UPD_DAC: begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (mask[i]) begin
                                next_st.dac[i] = st.inp[i];
                            end
                        end
                    end
                    CMD_WR_UPD_ALL: begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (mask[i]) begin
                                next_st.inp[i] = code;
                            end
                            next_st.dac[i] = next_st.inp[i];
                        end
                    end
                    CMD_WR_UPD: begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (mask[i]) begin
                                next_st.inp[i] = code;
                                next_st.dac[i] = code;
                            end
                        end
                    end
                    CMD_POWER: begin
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (link_word[i]) begin
                                next_st.pd[i] = link_word[PD_HI:PD_LO];
                                if (link_word[PD_HI:PD_LO] == PD_NORMAL &&
                                    st.pd[i] != PD_NORMAL && !load_outputs_n_s) begin
                                    next_st.dac[i] = st.inp[i];
                                end
                            end
                        end
                    end
                    CMD_CLR_SEL: begin
                        next_st.clr_sel = link_word[1:0];
                    end
                    CMD_LOAD_OUTPUTS_N_REG: begin
                        next_st.ovr = link_word[7:0];
                    end
                    CMD_SW_RESET: begin
                        next_st = POR_STATE;
                        next_st.tog_seen = tog_s;
                        next_st.clr_prev = clr_s;
                        next_st.load_outputs_n_prev = load_outputs_n_s;
                    end
                    CMD_REF_SETUP: begin
                        next_st.ref_en = link_word[REF_EN_BIT];
                        next_st.ref_sel = link_word[REF_SEL_BIT];
                    end
                    CMD_MULTI: begin
                        next_st.mb = link_word[MB_BIT];
                    end
                    default: begin
                        // Reserved codes are accepted and do nothing.
                        next_st.clr_act = st.clr_act;
                    end
                endcase
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            down[i] = next_st.pd[i] != PD_NORMAL;
        end
        next_st.ref_pwr = next_st.ref_en & ~(&down);
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= POR_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign o_dac_code = st.dac;
    assign o_power_mode = st.pd;
    assign o_ref_enable = st.ref_en;
    assign o_ref_select = st.ref_sel;
    assign o_ref_powered = st.ref_pwr;
    assign o_clear_active = st.clr_act;
    assign o_multi_byte = st.mb;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_valid;
        tog_ev && !st.discard && !clr_fall;
    endsequence

    sequence s_cmd(logic [3:0] c);
        s_valid ##0 (cmd == c);
    endsequence

    ref_setup_a: assert property (s_cmd(CMD_REF_SETUP) |=>
        o_ref_enable == $past(link_word[0]) && o_ref_select == $past(link_word[1]))
        else $error("reference set-up not applied");

    multi_byte_a: assert property (s_cmd(CMD_MULTI) |=>
        o_multi_byte == $past(link_word[22]))
        else $error("multi-byte mode not applied");

    power_mode_a: assert property (s_cmd(CMD_POWER) ##0 link_word[0] |=>
        o_power_mode[0] == $past(link_word[9:8]))
        else $error("power mode not applied to channel zero");

    pd_keep_a: assert property (s_cmd(CMD_POWER) ##0
        (link_word[9:8] != PD_NORMAL) && !load_outputs_n_fall |=> $stable(o_dac_code))
        else $error("power-down changed converter codes");

    ref_down_a: assert property ((o_power_mode[0] != PD_NORMAL) &&
        (o_power_mode[7] != PD_NORMAL) && o_ref_powered |-> (o_power_mode[3] == PD_NORMAL) ||
        (o_power_mode[1] == PD_NORMAL) || (o_power_mode[2] == PD_NORMAL) ||
        (o_power_mode[4] == PD_NORMAL) || (o_power_mode[5] == PD_NORMAL) ||
        (o_power_mode[6] == PD_NORMAL))
        else $error("reference powered with every channel down");

    clear_load_a: assert property (clr_fall && st.clr_sel != CLR_NOOP |=>
        o_dac_code[0] == clear_value($past(st.clr_sel)) && o_clear_active)
        else $error("clear code not loaded");

    clear_abort_a: assert property (clr_fall && frame_s |=> (st.discard and
        (tog_ev |=> $stable(st.inp))))
        else $error("write not aborted by clear");

    clear_exit_a: assert property (s_valid ##0 o_clear_active && (cmd < CMD_RSVD_FIRST) |=>
        !o_clear_active)
        else $error("clear state not left on write");

    reserved_a: assert property (s_valid ##0 (cmd >= CMD_RSVD_FIRST) && !load_outputs_n_fall |=>
        $stable(o_dac_code) && $stable(o_power_mode) && $stable(o_ref_enable))
        else $error("reserved command changed state");

    sw_reset_a: assert property (s_cmd(CMD_SW_RESET) |=>
        o_dac_code[5] == POR_CODE && !o_ref_enable && o_power_mode == '0)
        else $error("software reset incomplete");

    wr_upd_a: assert property (s_cmd(CMD_WR_UPD) ##0 (link_word[19:16] == 4'h2) |=>
        o_dac_code[2] == $past(code))
        else $error("write and update missed channel");

    bad_addr_a: assert property (s_cmd(CMD_WR_UPD) ##0 (mask == 8'h00) && !load_outputs_n_fall |=>
        $stable(o_dac_code))
        else $error("unknown address changed codes");

    por_state_a: assert property ($fell(i_sys_rst) |-> !o_ref_enable &&
        o_dac_code[0] == POR_CODE && st.clr_sel == CLR_ZERO)
        else $error("power-on state wrong");

    clear_noop_a: assert property (clr_fall && st.clr_sel == CLR_NOOP |=>
        $stable(o_dac_code) && $stable(o_clear_active))
        else $error("no-operation clear code changed state");

    clear_sel_a: assert property (s_cmd(CMD_CLR_SEL) |=>
        st.clr_sel == $past(link_word[1:0]))
        else $error("clear code selection not stored");

    override_a: assert property (s_cmd(CMD_LOAD_OUTPUTS_N_REG) |=>
        st.ovr == $past(link_word[7:0]))
        else $error("load override not stored");

    load_copy_a: assert property (load_outputs_n_fall && !clr_fall && !tog_ev && !st.ovr[1] |=>
        o_dac_code[1] == $past(st.inp[1]))
        else $error("load pin did not copy input register");

    upd_all_a: assert property (s_cmd(CMD_WR_UPD_ALL) |=> o_dac_code == st.inp)
        else $error("software load did not update all channels");

    wr_input_a: assert property (s_cmd(CMD_WR_INPUT) ##0 mask[2] |=>
        st.inp[2] == $past(code))
        else $error("input register write missed");

    upd_dac_a: assert property (s_cmd(CMD_UPD_DAC) ##0 mask[2] |=>
        o_dac_code[2] == $past(st.inp[2]))
        else $error("converter update missed");

    pd_up_a: assert property (s_cmd(CMD_POWER) ##0 link_word[1] && load_outputs_n_s &&
        (link_word[PD_HI:PD_LO] == PD_NORMAL) |=> $stable(o_dac_code[1]))
        else $error("power-up with load high changed the code");

    discard_end_a: assert property (st.discard && (tog_ev || !frame_s) && !clr_fall |=>
        !st.discard)
        else $error("discard state not released");
endmodule : octal_dac_command_decoder

// file: hw/dac_cmd_pkg.sv
// Shared constants, command codes and decode helpers for the octal converter command decoder.
// Assumes a 24-bit command word: command nibble, channel-address nibble, 16-bit data field.
package dac_cmd_pkg;
    localparam int WORD_BITS = 24;
    localparam int SHORT_BITS = 16;
    localparam int CNT_W = 5;
    localparam int NUM_CH = 8;
    localparam int CODE_W = 16;
    localparam int CMD_HI = 23;
    localparam int CMD_LO = 20;
    localparam int ADDR_HI = 19;
    localparam int ADDR_LO = 16;
    localparam int DATA_HI = 15;
    localparam int MB_BIT = 22;
    localparam int PD_HI = 9;
    localparam int PD_LO = 8;
    localparam int REF_EN_BIT = 0;
    localparam int REF_SEL_BIT = 1;
    localparam int LOW_PAD_W = 4;

    localparam logic [3:0] CMD_WR_INPUT = 4'h0;
    localparam logic [3:0] CMD_UPD_DAC = 4'h1;
    localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
    localparam logic [3:0] CMD_WR_UPD = 4'h3;
    localparam logic [3:0] CMD_POWER = 4'h4;
    localparam logic [3:0] CMD_CLR_SEL = 4'h5;
    localparam logic [3:0] CMD_LOAD_OUTPUTS_N_REG = 4'h6;
    localparam logic [3:0] CMD_SW_RESET = 4'h7;
    localparam logic [3:0] CMD_REF_SETUP = 4'h8;
    localparam logic [3:0] CMD_MULTI = 4'h9;
    localparam logic [3:0] CMD_RSVD_FIRST = 4'ha;
    localparam logic [3:0] ADDR_ALL = 4'hf;
    localparam logic [3:0] ADDR_LAST = 4'h7;

    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] CLR_ZERO = 2'h0;
    localparam logic [1:0] CLR_MID = 2'h1;
    localparam logic [1:0] CLR_FULL = 2'h2;
    localparam logic [1:0] CLR_NOOP = 2'h3;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_MID = 16'h8000;
    localparam logic [15:0] CODE_FULL = 16'hffff;
    localparam logic [3:0] SYNC_RST = 4'h3;

    function automatic logic [7:0] chan_mask(input logic [3:0] addr);
        logic [7:0] m;
        m = 8'h00;
        if (addr == ADDR_ALL) begin
            m = 8'hff;
        end else if (addr <= ADDR_LAST) begin
            m[addr[2:0]] = 1'b1;
        end
        return m;
    endfunction : chan_mask

    function automatic logic [15:0] data_code(input logic [23:0] w, input logic twelve);
        logic [15:0] c;
        c = w[DATA_HI:0];
        if (twelve) begin
            c[LOW_PAD_W-1:0] = '0;
        end
        return c;
    endfunction : data_code

    function automatic logic [15:0] clear_value(input logic [1:0] sel);
        logic [15:0] v;
        v = CODE_ZERO;
        if (sel == CLR_MID) begin
            v = CODE_MID;
        end else if (sel == CLR_FULL) begin
            v = CODE_FULL;
        end
        return v;
    endfunction : clear_value
endpackage : dac_cmd_pkg

// file: hw/level_sync.sv
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a slow level; multi-bit values must not rely on arriving together.
`timescale 1ns/100ps
module level_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    always_comb begin
        next_st.meta = i_async;
        next_st.stable = st.meta;
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= {RST_VAL, RST_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign o_sync = st.stable;
endmodule : level_sync

// file: hw/link_shifter.sv
// Serial word assembler running on the link clock.
// Assumes the frame level and data bit change away from the rising link clock edge.
// The link clock may stop between frames; the bit count clears at a link clock edge that sees the frame low or that completes a word.
`timescale 1ns/100ps
module link_shifter
    import dac_cmd_pkg::*;
(
    input wire logic i_link_clk,
    input wire logic i_sys_rst,
    input wire logic i_frame,
    input wire logic i_bit,
    input wire logic i_two_byte,
    output logic [23:0] o_word,
    output logic o_word_toggle
);
    typedef struct packed {
        logic [23:0] shift;
        logic [23:0] word;
        logic [CNT_W-1:0] cnt;
        logic [7:0] cmd_keep;
        logic have_cmd;
        logic toggle;
        logic mb_meta;
        logic mb;
    } shift_state_t;

    shift_state_t st;
    shift_state_t next_st;

    always_comb begin
        logic [23:0] shifted;
        logic [CNT_W-1:0] target;
        shifted = {st.shift[22:0], i_bit};
        target = (st.mb && st.have_cmd) ? CNT_W'(SHORT_BITS) : CNT_W'(WORD_BITS);
        next_st = st;
        next_st.mb_meta = i_two_byte;
        next_st.mb = st.mb_meta;
        if (!i_frame) begin
            next_st.cnt = '0;
            next_st.have_cmd = 1'b0;
        end else begin
            next_st.shift = shifted;
            next_st.cnt = st.cnt + 1'b1;
            if (st.cnt + 1'b1 == target) begin
                // Short transfers reuse the command byte of the frame's first word.
                next_st.word = (target == CNT_W'(SHORT_BITS)) ?
                    {st.cmd_keep, shifted[15:0]} : shifted;
                next_st.cmd_keep = next_st.word[CMD_HI:ADDR_LO];
                next_st.have_cmd = 1'b1;
                next_st.toggle = ~st.toggle;
                next_st.cnt = '0;
            end
        end
    end

    always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_word = st.word;
    assign o_word_toggle = st.toggle;
endmodule : link_shifter

// file: bench/link_master.sv
// Serial link master model that frames one command word at a time.
// Assumes a single caller; the data line has a pull-up and floats high between frames.
`timescale 1ns/100ps
module link_master (
    output logic o_link_clk,
    output logic o_link_frame,
    output logic o_link_bit
);
    initial begin
        o_link_clk = 1'b0;
        o_link_frame = 1'b0;
        o_link_bit = 1'b1;
    end
    // The clock stands still outside frames, so the design cannot lean on free-running edges.
    task automatic send(input logic [23:0] w);
        #7;
        o_link_frame = 1'b1;
        for (int i = 23; i >= 0; i--) begin
            o_link_bit = w[i];
            #40 o_link_clk = 1'b1;
            #40 o_link_clk = 1'b0;
        end
        #40 o_link_frame = 1'b0;
        o_link_bit = 1'b1;
        #40;
    endtask : send
endmodule : link_master

// file: bench/tb_top.sv
// Self-checking bench for the command decoder with a behavioural reference model.
// Assumes the link master model and the default full-width, zero power-on variant.
`timescale 1ns/100ps
module tb_top;
    import dac_cmd_pkg::*;
    logic i_mclk;
    logic i_sys_rst;
    logic ldn;
    logic cn;
    wire lclk;
    wire lfr;
    wire lbit;
    logic [7:0][15:0] o_dac_code;
    logic [7:0][1:0] o_power_mode;
    logic o_ref_enable;
    logic o_ref_select;
    logic o_ref_powered;
    logic o_clear_active;
    logic o_multi_byte;
    int errors;
    int comparisons;
    int in_r[8];
    int dac[8];
    int pm[8];
    int ovr;
    int csel;
    int ren;
    int rsel;
    int mb;
    int cact;
    int seed;

    link_master link_master_inst (.o_link_clk(lclk), .o_link_frame(lfr), .o_link_bit(lbit));
    octal_dac_command_decoder octal_dac_command_decoder_inst (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_link_clk(lclk), .i_link_frame(lfr),
        .i_link_bit(lbit), .i_load_outputs_n(ldn), .i_clear_n(cn), .o_dac_code(o_dac_code),
        .o_power_mode(o_power_mode), .o_ref_enable(o_ref_enable), .o_ref_select(o_ref_select),
        .o_ref_powered(o_ref_powered), .o_clear_active(o_clear_active),
        .o_multi_byte(o_multi_byte));

    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    task automatic print_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic m_reset();
        for (int ch = 0; ch < 8; ch++) begin
            in_r[ch] = 0;
            dac[ch] = 0;
            pm[ch] = 0;
        end
        ovr = 0;
        csel = 0;
        ren = 0;
        rsel = 0;
        mb = 0;
        cact = 0;
    endtask : m_reset

    task automatic compare_all();
        int alld;
        alld = 1;
        for (int ch = 0; ch < 8; ch++) begin
            check(32'(o_dac_code[ch]), dac[ch]);
            check(32'(o_power_mode[ch]), pm[ch]);
            if (pm[ch] == 0) begin
                alld = 0;
            end
        end
        check(32'(o_ref_enable), ren);
        check(32'(o_ref_select), rsel);
        check(32'(o_ref_powered), 32'(ren != 0 && alld == 0));
        check(32'(o_clear_active), cact);
        check(32'(o_multi_byte), mb);
    endtask : compare_all

    task automatic m_apply(input logic [23:0] w);
        int c;
        int a;
        int d;
        int m;
        c = w[23:20];
        a = w[19:16];
        d = w[15:0];
        m = (a == 15) ? 255 : (a < 8) ? (1 << a) : 0;
        if (c < 10) begin
            cact = 0;
        end
        for (int ch = 0; ch < 8; ch++) begin
            if (c < 4 && m[ch] && c != 1) begin
                in_r[ch] = d;
            end
            if ((c == 0 && m[ch] && (ldn == 0 || ovr[ch])) || (c == 3 && m[ch])) begin
                dac[ch] = d;
            end
            if ((c == 1 && m[ch]) || c == 2) begin
                dac[ch] = in_r[ch];
            end
            if (c == 4 && d[ch]) begin
                if (d[9:8] == 0 && pm[ch] != 0 && ldn == 0) begin
                    dac[ch] = in_r[ch];
                end
                pm[ch] = d[9:8];
            end
        end
        case (c)
            5: csel = d[1:0];
            6: ovr = d[7:0];
            7: m_reset();
            8: begin
                ren = d[0];
                rsel = d[1];
            end
            9: mb = w[22];
            default: ;
        endcase
    endtask : m_apply

    task automatic wr(input logic [23:0] w);
        link_master_inst.send(w);
        m_apply(w);
        repeat (4) @(negedge i_mclk);
        compare_all();
    endtask : wr

    task automatic clr_pulse();
        int v;
        @(negedge i_mclk);
        cn = 1'b0;
        v = (csel == 1) ? 32'h8000 : (csel == 2) ? 32'hffff : 0;
        if (csel != 3) begin
            cact = 1;
            for (int ch = 0; ch < 8; ch++) begin
                in_r[ch] = v;
                dac[ch] = v;
            end
        end
        repeat (6) @(negedge i_mclk);
        cn = 1'b1;
        repeat (3) @(negedge i_mclk);
    endtask : clr_pulse

    initial begin
        i_sys_rst = 1'b0;
        ldn = 1'b1;
        cn = 1'b1;
        errors = 0;
        comparisons = 0;
        m_reset();
        seed = $urandom(82765);
        // Reset rises after time zero so the link-side flops, with no clock yet, see its edge.
        #1 i_sys_rst = 1'b1;
        repeat (8) @(negedge i_mclk);
        cn = 1'b0;
        ldn = 1'b0;
        repeat (4) @(negedge i_mclk);
        cn = 1'b1;
        ldn = 1'b1;
        repeat (4) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        repeat (4) @(negedge i_mclk);
        compare_all();
        for (int ch = 0; ch < 8; ch++) begin
            wr({CMD_WR_UPD, 4'(ch), 16'($urandom)});
        end
        for (int a = 8; a < 15; a++) begin
            wr({CMD_WR_UPD, 4'(a), 16'($urandom)});
        end
        clr_pulse();
        compare_all();
        wr({CMD_WR_INPUT, 4'h2, 16'($urandom)});
        wr({CMD_UPD_DAC, 4'h2, 16'h0000});
        wr({CMD_WR_UPD_ALL, 4'h5, 16'($urandom)});
        wr({CMD_LOAD_OUTPUTS_N_REG, 4'h0, 16'h0081});
        wr({CMD_WR_INPUT, ADDR_ALL, 16'($urandom)});
        // Only channels still governed by the pin follow its falling edge.
        ldn = 1'b0;
        for (int ch = 0; ch < 8; ch++) begin
            dac[ch] = ovr[ch] ? dac[ch] : in_r[ch];
        end
        repeat (6) @(negedge i_mclk);
        compare_all();
        wr({CMD_WR_INPUT, 4'h3, 16'($urandom)});
        ldn = 1'b1;
        wr({CMD_REF_SETUP, 4'h0, 16'h0003});
        for (int m = 1; m < 4; m++) begin
            wr({CMD_POWER, 4'h0, 6'h00, 2'(m), 8'(8'h07 << (3 * (m - 1)))});
        end
        wr({CMD_WR_INPUT, 4'h1, 16'($urandom)});
        wr({CMD_POWER, 4'h0, 6'h00, 2'h0, 8'h02});
        for (int s = 0; s < 4; s++) begin
            wr({CMD_CLR_SEL, 4'h0, 14'h0000, 2'(s)});
            clr_pulse();
            compare_all();
        end
        wr({CMD_CLR_SEL, 4'h0, 16'h0002});
        clr_pulse();
        for (int c = 10; c < 16; c++) begin
            wr({4'(c), 4'hf, 16'($urandom)});
        end
        wr({CMD_MULTI, 4'h0, 16'($urandom)});
        wr({CMD_WR_UPD, 4'h4, 16'h1234});
        fork
            link_master_inst.send({CMD_WR_UPD, 4'h6, 16'h5a5a});
            begin
                repeat (200) @(negedge i_mclk);
                clr_pulse();
            end
        join
        repeat (4) @(negedge i_mclk);
        compare_all();
        wr({CMD_SW_RESET, 4'h0, 16'h0000});
        print_verdict();
    end

    // The full sequence needs roughly 90 us; a hang beyond 300 us is a failure.
    initial begin
        #300000;
        errors++;
        print_verdict();
    end
endmodule : tb_top
